// file: rtl/pdm_pkg.sv
package pdm_pkg;

   // Register byte addresses
   localparam logic [15:0] PDM_ADDR_AR_ABORT  = 16'h1A0A;
   localparam logic [15:0] PDM_ADDR_WARMUP    = 16'h1A0B;
   localparam logic [15:0] PDM_ADDR_COOLDOWN  = 16'h1A0C;
   localparam logic [15:0] PDM_ADDR_RECEIVER_CONTROL_A  = 16'h1A40;

   // Abort reason flag positions
   localparam int PDM_AR_SW_ABORT_BIT = 1;
   localparam int PDM_AR_BUSY_BIT     = 3;
   localparam int PDM_AR_RX_BIT       = 6;
   localparam logic [7:0] PDM_AR_MASK = 8'h4A;

   // Receiver control A field positions
   localparam int PDM_RXC_FLUSH_BIT = 3;
   localparam int PDM_RXC_EN_BIT    = 4;
   localparam int PDM_RXC_LOOP_BIT  = 5;
   localparam logic [7:0] PDM_RXC_MASK = 8'h38;

   // Values after reset
   localparam logic [7:0] PDM_RST_AR_ABORT = 8'h00;
   localparam logic [7:0] PDM_RST_WARMUP   = 8'h00;
   localparam logic [7:0] PDM_RST_COOLDOWN = 8'h00;
   localparam logic [7:0] PDM_RST_RECEIVER_CONTROL_A = 8'h00;

   // Power delay timing: count unit of 2**3 clocks plus extra clocks
   localparam int PDM_UNIT_SHIFT   = 3;
   localparam int PDM_WARMUP_EXTRA = 5;
   localparam int PDM_COOL_EXTRA   = 2;

   // Register access request
   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [7:0]  wdata;
   } pdm_reg_req_t;

   // Events from the auto-response engine
   typedef struct packed {
      logic rx_abort;
      logic line_busy;
      logic sw_abort;
   } pdm_ar_evt_t;

   // Transmitter power sequencing states
   typedef enum logic [1:0] {
      PDM_TX_IDLE   = 2'b00,
      PDM_TX_WARMUP = 2'b01,
      PDM_TX_ACTIVE = 2'b10,
      PDM_TX_COOL   = 2'b11
   } pdm_tx_state_t;

endpackage

// file: rtl/pdm_regs.sv
`timescale 1ns/100ps
// Contract
// - Set abort flags frozen until software clears
// - Several abort flags may set together
// - Bit 6 set on reception during waits
// - Bit 3 set on busy line after turnaround
// - Bit 1 set on software abort
// - Hardware sets flags, write one clears
// - Warmup waits count times eight plus five
// - Cooldown waits count times eight plus two
// - Loopback bit lets receiver hear own transmissions
// - Receiver enable bit starts and stops reception
// - Enable change applies after current reception
// - Hard or cable reset clears receiver enable
// - Resets ignored until enable set once
// - Detection persists after enable cleared
// - Protocol reset leaves receiver enable alone
// - Flush bit resets the receiver queue
// - Flush bit holds receiver until cleared
// - Protocol layer reset also resets receiver
module pdm_regs
   import pdm_pkg::*;
#(
   parameter int CNT_W = 11
) (
   // Clock and resets
   input  wire logic         i_ref_clk,
   input  wire logic         i_reset,
   input  wire logic         i_mac_soft_reset,
   input  wire logic         i_protocol_layer_reset,
   // Register access
   input  wire pdm_reg_req_t i_reg,
   output logic [7:0]        o_reg_rdata,
   // Auto-response abort causes
   input  wire pdm_ar_evt_t  i_ar_evt,
   output logic              o_auto_reply_aborted_event,
   // Transmitter power sequencing
   input  wire logic         i_tx_start,
   input  wire logic         i_tx_done,
   output logic              o_tx_power_on,
   output logic              o_tx_ready,
   // Receiver side
   input  wire logic         i_rx_busy,
   input  wire logic         i_hard_reset_seen,
   input  wire logic         i_cable_reset_seen,
   output logic              o_rx_enable,
   output logic              o_loopback,
   output logic              o_rx_queue_reset,
   output logic              o_link_reset_det
);

   // Counter must hold 255*8+4
   generate
      if (CNT_W < 11) begin : g_chk
         $error("CNT_W too small for power delay counts");
      end
   endgenerate

   // Package constants the datapath relies on
   generate
      if (PDM_WARMUP_EXTRA < 1 || PDM_COOL_EXTRA < 1) begin : g_chk_extra
         $error("Power delay extra clocks must be at least one");
      end
      if (PDM_AR_RX_BIT > 7 || PDM_AR_BUSY_BIT > 7
          || PDM_AR_SW_ABORT_BIT > 7) begin : g_chk_ar_pos
         $error("Abort flag position outside the register");
      end
      if (PDM_RXC_FLUSH_BIT > 7 || PDM_RXC_EN_BIT > 7
          || PDM_RXC_LOOP_BIT > 7) begin : g_chk_rxc_pos
         $error("Receiver control field outside the register");
      end
   endgenerate

   logic [7:0]          ar_abort_r;
   logic [7:0]          warmup_r;
   logic [7:0]          cooldown_r;
   logic [7:0]          rx_ctl_r;
   logic                rx_armed_r;
   pdm_tx_state_t       tx_state_r;
   logic [CNT_W-1:0]    tx_cnt_r;
   logic [7:0]          ar_set_nxt;
   logic                wr_abort;
   logic                wr_warm;
   logic                wr_cool;
   logic                wr_rxc;
   logic                link_reset;
   logic [CNT_W-1:0]    warm_load;
   logic [CNT_W-1:0]    cool_load;

   // Write decode
   always_comb begin
      wr_abort = 1'b0;
      wr_warm  = 1'b0;
      wr_cool  = 1'b0;
      wr_rxc   = 1'b0;
      if (i_reg.wr && i_reg.addr == PDM_ADDR_AR_ABORT) begin
         wr_abort = 1'b1;
      end else if (i_reg.wr && i_reg.addr == PDM_ADDR_WARMUP) begin
         wr_warm = 1'b1;
      end else if (i_reg.wr && i_reg.addr == PDM_ADDR_COOLDOWN) begin
         wr_cool = 1'b1;
      end else if (i_reg.wr && i_reg.addr == PDM_ADDR_RECEIVER_CONTROL_A) begin
         wr_rxc = 1'b1;
      end
   end

   // Abort causes gathered independently
   always_comb begin
      ar_set_nxt = 8'h00;
      ar_set_nxt[PDM_AR_RX_BIT]       = i_ar_evt.rx_abort;
      ar_set_nxt[PDM_AR_BUSY_BIT]     = i_ar_evt.line_busy;
      ar_set_nxt[PDM_AR_SW_ABORT_BIT] = i_ar_evt.sw_abort;
   end

   // Sticky abort reasons, write one to clear
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         ar_abort_r <= PDM_RST_AR_ABORT;
      end else if (i_mac_soft_reset) begin
         ar_abort_r <= PDM_RST_AR_ABORT;
      end else if (ar_abort_r != 8'h00) begin
         // Frozen for hardware while any flag stands
         if (wr_abort) begin
            ar_abort_r <= ar_abort_r & ~(i_reg.wdata & PDM_AR_MASK);
         end
      end else begin
         ar_abort_r <= ar_set_nxt;
      end
   end

   // Aborted event pulse on any flag setting
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_auto_reply_aborted_event <= 1'b0;
      end else begin
         o_auto_reply_aborted_event <= !i_mac_soft_reset
            && ar_abort_r == 8'h00 && ar_set_nxt != 8'h00;
      end
   end

   // Power-up delay count
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         warmup_r <= PDM_RST_WARMUP;
      end else if (i_mac_soft_reset) begin
         warmup_r <= PDM_RST_WARMUP;
      end else if (wr_warm) begin
         warmup_r <= i_reg.wdata;
      end
   end

   // Power-down delay count
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         cooldown_r <= PDM_RST_COOLDOWN;
      end else if (i_mac_soft_reset) begin
         cooldown_r <= PDM_RST_COOLDOWN;
      end else if (wr_cool) begin
         cooldown_r <= i_reg.wdata;
      end
   end

   // Delay reloads, one less since terminal count is zero
   assign warm_load = CNT_W'({warmup_r, {PDM_UNIT_SHIFT{1'b0}}})
                    + CNT_W'(PDM_WARMUP_EXTRA - 1);
   assign cool_load = CNT_W'({cooldown_r, {PDM_UNIT_SHIFT{1'b0}}})
                    + CNT_W'(PDM_COOL_EXTRA - 1);

   // Transmitter power sequencing, state and delay counter
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         tx_state_r <= PDM_TX_IDLE;
         tx_cnt_r   <= '0;
      end else if (i_mac_soft_reset) begin
         tx_state_r <= PDM_TX_IDLE;
         tx_cnt_r   <= '0;
      end else begin
         case (tx_state_r)
            PDM_TX_IDLE: begin
               if (i_tx_start) begin
                  tx_state_r <= PDM_TX_WARMUP;
                  tx_cnt_r   <= warm_load;
               end
            end
            PDM_TX_WARMUP: begin
               if (tx_cnt_r == '0) begin
                  tx_state_r <= PDM_TX_ACTIVE;
               end else begin
                  tx_cnt_r <= tx_cnt_r - CNT_W'(1);
               end
            end
            PDM_TX_ACTIVE: begin
               if (i_tx_done) begin
                  tx_state_r <= PDM_TX_COOL;
                  tx_cnt_r   <= cool_load;
               end
            end
            PDM_TX_COOL: begin
               if (tx_cnt_r == '0) begin
                  tx_state_r <= PDM_TX_IDLE;
               end else begin
                  tx_cnt_r <= tx_cnt_r - CNT_W'(1);
               end
            end
            default: begin
               tx_state_r <= PDM_TX_IDLE;
            end
         endcase
      end
   end

   // Power and ready levels follow the sequencer's transitions
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_tx_power_on <= 1'b0;
         o_tx_ready    <= 1'b0;
      end else if (i_mac_soft_reset) begin
         o_tx_power_on <= 1'b0;
         o_tx_ready    <= 1'b0;
      end else begin
         case (tx_state_r)
            PDM_TX_IDLE: begin
               if (i_tx_start) begin
                  o_tx_power_on <= 1'b1;
               end
            end
            PDM_TX_WARMUP: begin
               if (tx_cnt_r == '0) begin
                  o_tx_ready <= 1'b1;
               end
            end
            PDM_TX_ACTIVE: begin
               if (i_tx_done) begin
                  o_tx_ready <= 1'b0;
               end
            end
            PDM_TX_COOL: begin
               if (tx_cnt_r == '0) begin
                  o_tx_power_on <= 1'b0;
               end
            end
            default: begin
               o_tx_power_on <= 1'b0;
               o_tx_ready    <= 1'b0;
            end
         endcase
      end
   end

   // Link reset seen, only once receiver was armed
   assign link_reset = rx_armed_r
      && (i_hard_reset_seen || i_cable_reset_seen);

   // Receiver control; protocol reset does not touch it
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         rx_ctl_r <= PDM_RST_RECEIVER_CONTROL_A;
      end else if (i_mac_soft_reset) begin
         rx_ctl_r <= PDM_RST_RECEIVER_CONTROL_A;
      end else begin
         if (wr_rxc) begin
            rx_ctl_r <= i_reg.wdata & PDM_RXC_MASK;
         end
         if (link_reset) begin
            rx_ctl_r[PDM_RXC_EN_BIT] <= 1'b0;
         end
      end
   end

   // Arm link reset detection after first enable
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         rx_armed_r <= 1'b0;
      end else if (i_mac_soft_reset) begin
         rx_armed_r <= 1'b0;
      end else if (rx_ctl_r[PDM_RXC_EN_BIT]) begin
         rx_armed_r <= 1'b1;
      end
   end

   // Effective receiver enable, changes only between receptions or on soft reset
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_rx_enable <= 1'b0;
      end else if (i_mac_soft_reset) begin
         o_rx_enable <= 1'b0;
      end else if (!i_rx_busy) begin
         o_rx_enable <= rx_ctl_r[PDM_RXC_EN_BIT];
      end
   end

   // Loopback select
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_loopback <= 1'b0;
      end else begin
         o_loopback <= rx_ctl_r[PDM_RXC_LOOP_BIT];
      end
   end

   // Receiver queue held in reset
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_rx_queue_reset <= 1'b1;
      end else begin
         o_rx_queue_reset <= rx_ctl_r[PDM_RXC_FLUSH_BIT]
                          || i_protocol_layer_reset
                          || i_mac_soft_reset;
      end
   end

   // Accepted link reset pulse
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_link_reset_det <= 1'b0;
      end else begin
         o_link_reset_det <= link_reset && !i_mac_soft_reset;
      end
   end

   // Read data, unmapped reads as zero
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_reg_rdata <= 8'h00;
      end else if (!i_reg.rd) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg.addr == PDM_ADDR_AR_ABORT) begin
         o_reg_rdata <= ar_abort_r;
      end else if (i_reg.addr == PDM_ADDR_WARMUP) begin
         o_reg_rdata <= warmup_r;
      end else if (i_reg.addr == PDM_ADDR_COOLDOWN) begin
         o_reg_rdata <= cooldown_r;
      end else if (i_reg.addr == PDM_ADDR_RECEIVER_CONTROL_A) begin
         o_reg_rdata <= rx_ctl_r;
      end else begin
         o_reg_rdata <= 8'h00;
      end
   end

endmodule

// file: testbench/pdm_regs_properties.sv
`timescale 1ns/100ps
module pdm_regs_props
   import pdm_pkg::*;
(
   // Clock and resets
   input wire logic         i_ref_clk,
   input wire logic         i_reset,
   input wire logic         i_mac_soft_reset,
   input wire logic         i_protocol_layer_reset,
   // Register access
   input wire pdm_reg_req_t i_reg,
   input wire logic [7:0]   o_reg_rdata,
   // Abort events
   input wire pdm_ar_evt_t  i_ar_evt,
   input wire logic         o_auto_reply_aborted_event,
   // Transmitter
   input wire logic         i_tx_start,
   input wire logic         i_tx_done,
   input wire logic         o_tx_power_on,
   input wire logic         o_tx_ready,
   // Receiver
   input wire logic         i_rx_busy,
   input wire logic         i_hard_reset_seen,
   input wire logic         i_cable_reset_seen,
   input wire logic         o_rx_enable,
   input wire logic         o_loopback,
   input wire logic         o_rx_queue_reset,
   input wire logic         o_link_reset_det
);
   // One clock domain, power-on reset
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_reset);

   chk_event_has_cause: assert property (
      o_auto_reply_aborted_event |-> $past(i_ar_evt) != 3'b000)
      else $error("aborted event without a cause");
   chk_event_one_shot: assert property (
      o_auto_reply_aborted_event |=> !o_auto_reply_aborted_event)
      else $error("aborted event repeated while flags held");
   chk_power_on_start: assert property (
      $rose(o_tx_power_on) |-> $past(i_tx_start))
      else $error("transmitter powered without a start");
   chk_ready_needs_power: assert property (
      o_tx_ready |-> o_tx_power_on)
      else $error("ready while transmitter unpowered");
   chk_warmup_minimum: assert property (
      $rose(o_tx_power_on) |=> !o_tx_ready [*4])
      else $error("ready before five warmup clocks");
   chk_enable_held_busy: assert property (
      i_rx_busy && !i_mac_soft_reset && !$past(i_mac_soft_reset)
      |=> $stable(o_rx_enable))
      else $error("receiver enable changed during reception");
   chk_link_clears_en: assert property (
      o_link_reset_det && !i_rx_busy |=> !o_rx_enable)
      else $error("receiver still enabled after link reset");
   chk_link_det_cause: assert property (
      o_link_reset_det
      |-> $past(i_hard_reset_seen) || $past(i_cable_reset_seen))
      else $error("link reset flagged without a cause");
   chk_proto_resets_rx: assert property (
      i_protocol_layer_reset |=> o_rx_queue_reset)
      else $error("receiver queue not held by protocol reset");

   // Main scenarios reached
   cov_abort_event: cover property (o_auto_reply_aborted_event);
   cov_link_reset: cover property (o_link_reset_det);
   cov_tx_ready: cover property ($rose(o_tx_ready));
endmodule

bind pdm_regs pdm_regs_props u_props (.*);

// file: testbench/tb.sv
`timescale 1ns/100ps
module tb;
   import pdm_pkg::*;
   // Stimulus and observed signals
   logic         i_ref_clk = 0, i_reset = 1, i_mac_soft_reset = 0;
   logic         i_protocol_layer_reset = 0, i_tx_start = 0, i_tx_done = 0;
   logic         i_rx_busy = 0, i_hard_reset_seen = 0, i_cable_reset_seen = 0;
   pdm_reg_req_t i_reg = '0;
   pdm_ar_evt_t  i_ar_evt = '0;
   logic [7:0]   o_reg_rdata, rv;
   logic         o_auto_reply_aborted_event, o_tx_power_on, o_tx_ready, ev;
   logic         o_rx_enable, o_loopback, o_rx_queue_reset, o_link_reset_det;
   int           miscompares = 0, num_checks = 0, n;

   pdm_regs DUT (.*);

   // Clock of 20 ns
   always #10 i_ref_clk = ~i_ref_clk;

   // Step to just after a rising edge
   task automatic tick(input int k = 1);
      repeat (k) @(posedge i_ref_clk);
      #1;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Register write and read, idle cycle after each
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      i_reg = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      tick();
      i_reg = '0;
      tick();
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      i_reg = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      tick();
      chk("read data", o_reg_rdata, exp);
      i_reg = '0;
      tick();
   endtask

   // Abort cause pulse, event sampled in the following cycle
   task automatic evt(input pdm_ar_evt_t e);
      i_ar_evt = e;
      tick();
      ev = o_auto_reply_aborted_event;
      i_ar_evt = '0;
      tick();
   endtask

   // Hard or cable reset pulse from the decoder
   task automatic link(input logic cable);
      i_hard_reset_seen = !cable;
      i_cable_reset_seen = cable;
      tick();
      ev = o_link_reset_det;
      i_hard_reset_seen = 0;
      i_cable_reset_seen = 0;
      tick();
   endtask

   task automatic t_abort();
      evt(3'b100);
      chk("event", ev, 1);
      evt(3'b010);
      chk("event held", ev, 0);
      rd(PDM_ADDR_AR_ABORT, 8'h40);
      wr(PDM_ADDR_AR_ABORT, 8'h00);
      rd(PDM_ADDR_AR_ABORT, 8'h40);
      wr(PDM_ADDR_AR_ABORT, 8'h40);
      rd(PDM_ADDR_AR_ABORT, 8'h00);
      evt(3'b011);
      chk("event two", ev, 1);
      rd(PDM_ADDR_AR_ABORT, 8'h0A);
      wr(PDM_ADDR_AR_ABORT, 8'hFF);
      rd(PDM_ADDR_AR_ABORT, 8'h00);
   endtask

   task automatic t_tx();
      // At 50 MHz: 32 units give 5.22us, 7 units give 1.16us
      wr(PDM_ADDR_WARMUP, 8'h20);
      wr(PDM_ADDR_COOLDOWN, 8'h07);
      rd(PDM_ADDR_WARMUP, 8'h20);
      rd(PDM_ADDR_COOLDOWN, 8'h07);
      i_tx_start = 1;
      tick();
      i_tx_start = 0;
      chk("power on", o_tx_power_on, 1);
      for (n = 0; !o_tx_ready && n < 300; n++) begin
         tick();
      end
      chk("warmup clocks", 16'(n), 16'(32 * 8 + 5));
      i_tx_done = 1;
      tick();
      i_tx_done = 0;
      chk("ready off", o_tx_ready, 0);
      for (n = 0; o_tx_power_on && n < 300; n++) begin
         tick();
      end
      chk("cooldown clocks", 16'(n), 16'(7 * 8 + 2));
   endtask

   task automatic t_rx();
      link(0);
      chk("unarmed", ev, 0);
      wr(PDM_ADDR_RECEIVER_CONTROL_A, 8'h30);
      chk("enable", o_rx_enable, 1);
      chk("loopback", o_loopback, 1);
      i_rx_busy = 1;
      wr(PDM_ADDR_RECEIVER_CONTROL_A, 8'h20);
      chk("enable busy", o_rx_enable, 1);
      i_rx_busy = 0;
      tick();
      chk("enable idle", o_rx_enable, 0);
      wr(PDM_ADDR_RECEIVER_CONTROL_A, 8'h30);
      i_protocol_layer_reset = 1;
      tick();
      chk("queue proto", o_rx_queue_reset, 1);
      rd(PDM_ADDR_RECEIVER_CONTROL_A, 8'h30);
      i_protocol_layer_reset = 0;
      link(1);
      chk("cable det", ev, 1);
      rd(PDM_ADDR_RECEIVER_CONTROL_A, 8'h20);
      link(0);
      chk("hard det", ev, 1);
      wr(PDM_ADDR_RECEIVER_CONTROL_A, 8'h28);
      tick(3);
      chk("queue flush", o_rx_queue_reset, 1);
      wr(PDM_ADDR_RECEIVER_CONTROL_A, 8'h20);
      chk("queue free", o_rx_queue_reset, 0);
      i_mac_soft_reset = 1;
      tick();
      i_mac_soft_reset = 0;
      tick();
      rd(PDM_ADDR_RECEIVER_CONTROL_A, 8'h00);
      link(0);
      chk("soft unarmed", ev, 0);
   endtask

   task automatic end_sim();
      if (miscompares == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Main sequence: reset values, unmapped place, then scenarios
   initial begin
      tick(12);
      i_reset = 0;
      tick();
      rd(PDM_ADDR_AR_ABORT, PDM_RST_AR_ABORT);
      rd(PDM_ADDR_WARMUP, PDM_RST_WARMUP);
      rd(PDM_ADDR_RECEIVER_CONTROL_A, PDM_RST_RECEIVER_CONTROL_A);
      wr(16'h1A0D, 8'hFF);
      rd(16'h1A0D, 8'h00);
      t_abort();
      t_tx();
      t_rx();
      end_sim();
   end

   // Watchdog far beyond the few hundred cycles needed
   initial begin
      #100000;
      miscompares++;
      end_sim();
   end
endmodule
